/* verilog/spd_port.sv */
// Behaviour
// - Direction-load copies accumulator into direction
// - Direction one tristates the pin driver
// - Direction zero drives latch onto pin
// - Input-only pin never drives; others configurable
// - Option register can override timer pin
// - Port read returns pin levels, not latch
// - Direction write-only, reset to all ones
// - Inputs not latched; sampled at read
// - Output latch holds until next write
// - Port bits seven and six read zero
// - Wake flag set on wake reset only
// - Bit set/clear rewrites whole latch from pins
// - Write lands at cycle end, read samples start
// - External timer clock forces timer pin input
// - Alternate-function pins read as zero
`include "spd_consts.svh"

module spd_port #(
	parameter int NPINS = `SPD_NPINS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wake_reset,
	input wire spd_pkg::spd_op_e op,
	input wire logic [7:0] op_addr,
	input wire logic [2:0] op_bit,
	input wire logic [7:0] acc,
	input wire logic dir_load,
	input wire logic opt_load,
	input wire logic [5:0] alt_func,
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic pin_change_wake_flag
);

	// ****************************************
	// Registers
	// ****************************************
	logic [5:0] dir_q;
	logic [7:0] opt_q;
	logic [5:0] latch_q;
	logic [5:0] latch_d;
	logic [5:0] oe_d;
	logic [5:0] pin_vis;
	logic port_hit;
	logic wake_q;

	spd_if pif ();

	spd_pads u_pads (
		.clk(clk),
		.nrst(nrst),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.bus(pif)
	);

	assign port_hit = (op_addr == `SPD_ADDR_PORT);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			dir_q <= `SPD_DIR_RESET;
		end else if (dir_load) begin
			dir_q <= acc[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			opt_q <= `SPD_OPT_RESET;
		end else if (opt_load) begin
			opt_q <= acc;
		end
	end

	// Pin levels as seen by a read; alternate-function pins forced low
	assign pin_vis = pif.pin_sync & ~alt_func;

	// ****************************************
	// Output latch update
	// ****************************************
	always_comb begin
		latch_d = latch_q;
		if (port_hit) begin
			case (op)
				spd_pkg::SPD_OP_WRITE: latch_d = acc[5:0];
				spd_pkg::SPD_OP_BSET: begin
					latch_d = pin_vis;
					if (op_bit < 3'(NPINS)) begin
						latch_d[op_bit] = 1'b1;
					end
				end
				spd_pkg::SPD_OP_BCLR: begin
					latch_d = pin_vis;
					if (op_bit < 3'(NPINS)) begin
						latch_d[op_bit] = 1'b0;
					end
				end
				default: latch_d = latch_q;
			endcase
		end
	end

	// Latch is not cleared by reset: unchanged by non-power resets
	always_ff @(posedge clk) begin
		latch_q <= latch_d;
	end

	// ****************************************
	// Driver enables
	// ****************************************
	always_comb begin
		oe_d = ~dir_q;
		oe_d[`SPD_INPUT_ONLY_PIN] = 1'b0;
		if (opt_q[`SPD_OPT_TCS_BIT]) begin
			oe_d[`SPD_TIMER_PIN] = 1'b0;
		end
	end

	assign pif.pad_out = latch_d;
	assign pif.pad_oe = oe_d;

	// ****************************************
	// Read path and status
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= (op == spd_pkg::SPD_OP_READ) &&
				(port_hit || op_addr == `SPD_ADDR_STATUS);
			if (op == spd_pkg::SPD_OP_READ && port_hit) begin
				rd_data <= {2'b00, pin_vis};
			end else if (op == spd_pkg::SPD_OP_READ) begin
				rd_data <= {wake_q, 7'h00};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wake_q <= wake_reset;
		end
	end

	assign pin_change_wake_flag = wake_q;

	// ****************************************
	// Checks
	// ****************************************
	// Latch holds unknown contents until the first port update after reset
	logic latch_known_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			latch_known_q <= 1'b0;
		end else if (port_hit && op != spd_pkg::SPD_OP_IDLE &&
			op != spd_pkg::SPD_OP_READ) begin
			latch_known_q <= 1'b1;
		end
	end

	// Direction and driver enables
	a_input_only_off: assert property (@(posedge clk) disable iff (!nrst)
		##1 !pin_oe[`SPD_INPUT_ONLY_PIN]) else $error("input-only pin driven");
	a_dir_reset_off: assert property (@(posedge clk)
		!nrst ##1 !nrst |=> pin_oe == 6'h00) else $error("driver on after reset");
	a_dir_load_oe: assert property (@(posedge clk) disable iff (!nrst)
		dir_load && !opt_load ##1 !dir_load |=> pin_oe[1:0] == ~$past(acc[1:0], 2))
		else $error("direction not applied");
	a_dir_one_off: assert property (@(posedge clk) disable iff (!nrst)
		dir_load && acc[1] |-> ##2 !pin_oe[1]) else $error("input pin still driven");
	a_timer_forced: assert property (@(posedge clk) disable iff (!nrst)
		opt_q[`SPD_OPT_TCS_BIT] |=> !pin_oe[`SPD_TIMER_PIN]) else $error("timer pin driven");
	a_timer_released: assert property (@(posedge clk) disable iff (!nrst)
		!opt_q[`SPD_OPT_TCS_BIT] && !dir_q[`SPD_TIMER_PIN] |=> pin_oe[`SPD_TIMER_PIN])
		else $error("timer pin not driven");

	// Output latch and pins
	a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_WRITE && port_hit |=> latch_q == $past(acc[5:0]))
		else $error("port write lost");
	a_write_pin: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_WRITE && port_hit |=> pin_out == $past(acc[5:0]))
		else $error("write not on pins");
	a_latch_holds: assert property (@(posedge clk) disable iff (!nrst)
		latch_known_q && !port_hit |=> $stable(latch_q)) else $error("latch changed");
	a_drive_latch: assert property (@(posedge clk) disable iff (!nrst)
		latch_known_q |-> (pin_out & pin_oe) == (latch_q & pin_oe))
		else $error("driven level not latch");
	a_bit_set: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_BSET && port_hit |=>
		latch_q == ($past(pin_vis) | (6'h01 << $past(op_bit)))) else $error("bit set wrong");
	a_bit_clear: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_BCLR && port_hit |=>
		latch_q == ($past(pin_vis) & ~(6'h01 << $past(op_bit)))) else $error("bit clear wrong");

	// Read path and wake flag
	a_read_high_zero: assert property (@(posedge clk) disable iff (!nrst)
		$past(port_hit) && rd_valid |-> rd_data[7:6] == 2'b00) else $error("bits 7:6 set");
	a_read_pins: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_READ && port_hit |=> rd_data[5:0] == $past(pin_vis))
		else $error("read not pin level");
	a_alt_zero: assert property (@(posedge clk) disable iff (!nrst)
		op == spd_pkg::SPD_OP_READ && port_hit |=> (rd_data[5:0] & $past(alt_func)) == 6'h00)
		else $error("alternate pin read high");
	a_wake_capture: assert property (@(posedge clk)
		!nrst |=> pin_change_wake_flag == $past(wake_reset)) else $error("wake flag wrong");
	a_wake_stable: assert property (@(posedge clk) disable iff (!nrst)
		##1 $stable(pin_change_wake_flag)) else $error("wake flag moved");

	c_port_read: cover property (@(posedge clk) op == spd_pkg::SPD_OP_READ && port_hit);
	c_bit_set: cover property (@(posedge clk) op == spd_pkg::SPD_OP_BSET && port_hit);
	c_bit_clear: cover property (@(posedge clk) op == spd_pkg::SPD_OP_BCLR && port_hit);
	c_dir_load: cover property (@(posedge clk) dir_load ##2 pin_oe != 6'h00);
	c_wake_reset: cover property (@(posedge clk) $rose(nrst) && pin_change_wake_flag);

endmodule // spd_port

/* verilog/spd_consts.svh */
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// Register file addresses
`define SPD_ADDR_STATUS 8'h03
`define SPD_ADDR_PORT 8'h06

// Widths and reset values
`define SPD_NPINS 6
`define SPD_DIR_RESET 6'h3f
`define SPD_OPT_RESET 8'hff
`define SPD_LATCH_RESET 6'h00

// Field positions
`define SPD_OPT_TCS_BIT 5
`define SPD_STAT_WAKE_BIT 7
`define SPD_INPUT_ONLY_PIN 3
`define SPD_TIMER_PIN 2

`endif

/* verilog/spd_pkg.sv */
package spd_pkg;

	// Instruction-cycle operation presented by the core
	typedef enum logic [4:0] {
		SPD_OP_IDLE = 5'b0_0001,
		SPD_OP_READ = 5'b0_0010,
		SPD_OP_WRITE = 5'b0_0100,
		SPD_OP_BSET = 5'b0_1000,
		SPD_OP_BCLR = 5'b1_0000
	} spd_op_e;

	typedef logic [5:0] spd_pins_t;

endpackage

/* verilog/spd_if.sv */
// Pin-side signals between the port core and the pad stage
interface spd_if;
	logic [5:0] pin_sync;
	logic [5:0] pad_out;
	logic [5:0] pad_oe;

	modport core (input pin_sync, output pad_out, output pad_oe);
	modport pads (output pin_sync, input pad_out, input pad_oe);
endinterface

/* verilog/spd_pads.sv */
`include "spd_consts.svh"

// Pad stage: two-flop input synchroniser, registered drivers
module spd_pads (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe,
	spd_if.pads bus
);

	logic [5:0] meta_q;
	logic [5:0] sync_q;

	always_ff @(posedge clk) begin
		meta_q <= pin_in;
		sync_q <= meta_q;
	end

	assign bus.pin_sync = sync_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_out <= `SPD_LATCH_RESET;
			pin_oe <= 6'h00;
		end else begin
			pin_out <= bus.pad_out;
			pin_oe <= bus.pad_oe;
		end
	end

endmodule // spd_pads

/* test/spd_ext.sv */
// External circuit on the pins: pull-ups, optional forced levels
module spd_ext (
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] ext_en,
	input wire logic [5:0] ext_val,
	output logic [5:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside force wins over the driver; released lines pull high
	assign pin_in = (ext_en & ext_val) | (~ext_en & ((pin_oe & pin_out) | ~pin_oe));
endmodule // spd_ext

/* test/spd_port_tb_top.sv */
module spd_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, wake_reset, dir_load, opt_load, rd_valid, wflag;
	spd_pkg::spd_op_e op;
	logic [7:0] op_addr, acc, rd_data;
	logic [2:0] op_bit;
	logic [5:0] alt_func, pin_in, pin_out, pin_oe, ext_en, ext_val;
	int num_errors, checks_done;
	spd_port u_dut (.clk(clk), .nrst(nrst), .wake_reset(wake_reset), .op(op),
		.op_addr(op_addr), .op_bit(op_bit), .acc(acc), .dir_load(dir_load),
		.opt_load(opt_load), .alt_func(alt_func), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .rd_data(rd_data), .rd_valid(rd_valid),
		.pin_change_wake_flag(wflag));
	spd_ext u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input spd_pkg::spd_op_e o, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] v, input logic dl, input logic ol);
		@(negedge clk);
		op = o; op_addr = a; op_bit = b; acc = v; dir_load = dl; opt_load = ol;
		@(negedge clk);
		op = spd_pkg::SPD_OP_IDLE; dir_load = 1'b0; opt_load = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cyc(spd_pkg::SPD_OP_READ, a, 3'h0, 8'h00, 1'b0, 1'b0);
		chk({7'h00, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] v);
		cyc(spd_pkg::SPD_OP_WRITE, 8'h06, 3'h0, v, 1'b0, 1'b0);
	endtask
	task automatic dir(input logic [7:0] v, input logic ol);
		cyc(spd_pkg::SPD_OP_IDLE, 8'h00, 3'h0, v, ~ol, ol);
		settle();
	endtask
	task automatic do_reset(input logic w);
		@(negedge clk);
		nrst = 1'b0; wake_reset = w;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		chk({2'h0, pin_oe}, 8'h00);
		chk({7'h00, wflag}, {7'h00, w});
		rd(8'h03, {w, 7'h00});
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		op = spd_pkg::SPD_OP_IDLE; op_addr = 8'h00; op_bit = 3'h0; acc = 8'h00;
		nrst = 1'b0; wake_reset = 1'b0; dir_load = 1'b0; opt_load = 1'b0;
		alt_func = 6'h00; ext_en = 6'h00; ext_val = 6'h00;
		do_reset(1'b1);
		ext_en = 6'h3f; ext_val = 6'h2a; settle();
		rd(8'h06, 8'h2a);
		ext_val = 6'h15; alt_func = 6'h05; settle();
		rd(8'h06, 8'h10);
		alt_func = 6'h00; ext_en = 6'h00;
		wr(8'hff);
		dir(8'h00, 1'b0);
		chk({2'h0, pin_oe & pin_out}, 8'h33);
		rd(8'h06, 8'h3f);
		ext_en = 6'h02; settle();
		rd(8'h06, 8'h3d);
		chk({2'h0, pin_oe & pin_out}, 8'h33);
		ext_en = 6'h00;
		dir(8'h20, 1'b1);
		chk({2'h0, pin_oe}, 8'h33);
		dir(8'h00, 1'b1);
		chk({2'h0, pin_oe}, 8'h37);
		wr(8'h00);
		dir(8'h02, 1'b0);
		ext_en = 6'h02; ext_val = 6'h02; settle();
		cyc(spd_pkg::SPD_OP_BCLR, 8'h06, 3'h5, 8'h00, 1'b0, 1'b0);
		ext_en = 6'h00;
		dir(8'h00, 1'b0);
		chk({2'h0, pin_oe & pin_out}, 8'h02);
		cyc(spd_pkg::SPD_OP_BSET, 8'h06, 3'h4, 8'h00, 1'b0, 1'b0);
		settle();
		chk({2'h0, pin_oe & pin_out}, 8'h12);
		wr(8'h2d);
		rd(8'h06, 8'h1a);
		settle();
		rd(8'h06, 8'h2d);
		dir(8'h3f, 1'b0);
		chk({2'h0, pin_oe}, 8'h00);
		do_reset(1'b0);
		complete_run();
	end
	initial begin
		#20000;
		num_errors++;
		complete_run();
	end
endmodule // spd_port_tb_top
